// file: rtl/ccs_sequencer.sv
// Frame sequencer that drives an interline CCD through its clock pins
// What this block does
// - Every clocked sensor pin gets one of seven patterns, mapped by readout mode.
// - At least 632 or 1264 lines are counted per frame, by mode.
// - Vertical rising edges coincide with or lead the falling edge in the same interval.
// - Phase four rises no later than phase one falls from high to mid, except upper pins in dual a/b and single modes, one vertical step later.
// - At least 1213 or 2426 pixel clocks are issued per line, by mode.
// - Each last-phase output copies its register's phase-two storage clock.
// - The substrate pulse is optional and stays low when shuttering is off.
// - Exposure runs from substrate falling to the next phase one falling.
// - Unused c/d register clocks may be held off in dual or single modes.
`timescale 1ns/1ps
`default_nettype none
`include "ccs_regs.svh"
module ccs_sequencer (
   input  wire logic        i_clk_sys,
   input  wire logic        i_rstn,
   input  wire logic        i_start,
   input  wire logic [1:0]  i_mode,
   input  wire logic        i_shutter_en,
   input  wire logic [15:0] i_expo_cycles,
   input  wire logic [11:0] i_extra_lines,
   input  wire logic        i_unused_off,
   input  wire logic        i_line_ready,
   output logic             o_line_valid,
   output ccs_pkg::ccs_line_t o_line,
   output ccs_pkg::ccs_pins_t o_pins,
   output logic             o_busy,
   output logic             o_frame_done
);
   ccs_pkg::ccs_state_t  state_reg;
   ccs_pkg::ccs_state_t  state_next;
   ccs_pkg::ccs_pattern_t pat_reg;
   ccs_pkg::ccs_pattern_t pat_next;
   logic [15:0]          tmr_reg;
   logic [15:0]          tmr_next;
   logic [11:0]          line_reg;
   logic [11:0]          pix_reg;
   logic [3:0]           div_reg;
   logic                 busy_reg;
   logic                 done_reg;
   logic [4:0]           sub_len_reg;
   logic [1:0]           step_reg;

   function automatic logic long_mode(input logic [1:0] m);
      long_mode = (m == `CCS_MODE_DUAL_AB) || (m == `CCS_MODE_SINGLE);
   endfunction

   wire [11:0] lines_min  = long_mode(i_mode) ? `CCS_LINES_LONG : `CCS_LINES_SHORT;
   wire [11:0] pix_min    = long_mode(i_mode) ? `CCS_PIX_LONG : `CCS_PIX_SHORT;
   wire [11:0] lines_tot  = lines_min + i_extra_lines;
   wire        pix_tick   = (div_reg == `CCS_PIX_DIV - 4'h1);
   wire        tmr_zero   = (tmr_reg == 16'h0);
   wire        last_line  = (line_reg == lines_tot - 12'h1);
   wire        last_pix   = (pix_reg == pix_min - 12'h1);
   wire        buf_ready;
   wire        ev_push    = (state_reg == ccs_pkg::ST_HDELAY) && tmr_zero;
   // Shift waits if the line-start buffer is full
   wire        shift_go   = buf_ready;
   ccs_pkg::ccs_line_t ev_data;
   assign ev_data.line_start = 1'b1;
   assign ev_data.line_idx   = line_reg;

   always_comb begin
      state_next = state_reg;
      tmr_next   = tmr_zero ? 16'h0 : tmr_reg - 16'h1;
      pat_next   = pat_reg;
      pat_next.sub = 1'b0;
      pat_next.p5  = 1'b0;
      pat_next.p6  = 1'b0;
      pat_next.p7  = 1'b0;
      case (state_reg)
         ccs_pkg::ST_IDLE: begin
            pat_next.p1t = 2'h1;
            pat_next.p1b = 2'h1;
            if (i_start) begin
               if (i_shutter_en) begin
                  state_next   = ccs_pkg::ST_SHUT;
                  tmr_next     = 16'(`CCS_T_SUB_CYC - 1);
                  pat_next.sub = 1'b1;
               end else begin
                  state_next = ccs_pkg::ST_PDXFER;
                  tmr_next   = 16'(`CCS_T_PD_CYC - 1);
                  pat_next.p1t = 2'h2;
                  pat_next.p1b = 2'h2;
               end
            end
         end
         ccs_pkg::ST_SHUT: begin
            pat_next.sub = 1'b1;
            if (tmr_zero) begin
               pat_next.sub = 1'b0;
               state_next   = ccs_pkg::ST_EXPO;
               tmr_next     = (i_expo_cycles > 16'(`CCS_T_HD_CYC)) ? i_expo_cycles : 16'(`CCS_T_HD_CYC);
            end
         end
         ccs_pkg::ST_EXPO: begin
            if (tmr_zero) begin
               state_next   = ccs_pkg::ST_PDXFER;
               tmr_next     = 16'(`CCS_T_PD_CYC - 1);
               pat_next.p1t = 2'h2;
               pat_next.p1b = 2'h2;
            end
         end
         ccs_pkg::ST_PDXFER: begin
            if (tmr_zero) begin
               // Phase four rises with phase one leaving high; transfer on the drop
               pat_next.p1t = 2'h1;
               pat_next.p1b = 2'h1;
               pat_next.p4t = 1'b1;
               pat_next.p4b = 1'b1;
               state_next   = ccs_pkg::ST_VSHIFT;
               tmr_next     = 16'(`CCS_T_V_CYC - 1);
            end
         end
         ccs_pkg::ST_VSHIFT: begin
            // Four rotation steps move one row; rising phase changes in the same cycle as the falling one in each step
            if (tmr_zero && shift_go) begin
               pat_next.p2t = pat_reg.p1t[0];
               pat_next.p2b = pat_reg.p1b[0];
               pat_next.p3t = pat_reg.p2t;
               pat_next.p3b = pat_reg.p2b;
               pat_next.p4t = pat_reg.p3t;
               pat_next.p4b = pat_reg.p3b;
               pat_next.p1t = {1'b0, pat_reg.p4t};
               pat_next.p1b = {1'b0, pat_reg.p4b};
               tmr_next     = 16'(`CCS_T_V_CYC - 1);
               if (step_reg == 2'h3) begin
                  state_next = ccs_pkg::ST_HDELAY;
                  tmr_next   = 16'(`CCS_T_HS_CYC - 1);
               end
            end
         end
         ccs_pkg::ST_HDELAY: begin
            if (tmr_zero)
               state_next = ccs_pkg::ST_PIXELS;
         end
         ccs_pkg::ST_PIXELS: begin
            pat_next.p5 = pat_reg.p5;
            pat_next.p6 = pat_reg.p6;
            pat_next.p7 = 1'b0;
            if (pix_tick) begin
               pat_next.p5 = pat_reg.p6;
               pat_next.p6 = ~pat_reg.p6;
               pat_next.p7 = ~pat_reg.p6;
               if (pat_reg.p6 && last_pix) begin
                  pat_next.p5 = 1'b0;
                  pat_next.p6 = 1'b0;
                  if (last_line) begin
                     state_next = ccs_pkg::ST_IDLE;
                  end else begin
                     state_next = ccs_pkg::ST_VSHIFT;
                     tmr_next   = 16'(`CCS_T_V_CYC - 1);
                  end
               end
            end
         end
         default: state_next = ccs_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         state_reg <= ccs_pkg::ST_IDLE;
         tmr_reg   <= 16'h0;
         pat_reg   <= '0;
      end else begin
         state_reg <= state_next;
         tmr_reg   <= tmr_next;
         pat_reg   <= pat_next;
      end
   end

   // Pixel divider; restarted at each line so all registers share one rate
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn)
         div_reg <= 4'h0;
      else if (state_reg != ccs_pkg::ST_PIXELS || pix_tick)
         div_reg <= 4'h0;
      else
         div_reg <= div_reg + 4'h1;
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         pix_reg  <= 12'h0;
         line_reg <= 12'h0;
         step_reg <= 2'h0;
      end else begin
         if (state_reg != ccs_pkg::ST_VSHIFT)
            step_reg <= 2'h0;
         else if (tmr_zero && shift_go)
            step_reg <= step_reg + 2'h1;
         if (state_reg != ccs_pkg::ST_PIXELS)
            pix_reg <= 12'h0;
         else if (pix_tick && pat_reg.p6)
            pix_reg <= pix_reg + 12'h1;
         if (state_reg == ccs_pkg::ST_IDLE)
            line_reg <= 12'h0;
         else if (state_reg == ccs_pkg::ST_PIXELS && pix_tick && pat_reg.p6 && last_pix)
            line_reg <= line_reg + 12'h1;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         busy_reg    <= 1'b0;
         done_reg    <= 1'b0;
         sub_len_reg <= 5'h00;
      end else begin
         busy_reg    <= (state_next != ccs_pkg::ST_IDLE);
         done_reg    <= (state_reg != ccs_pkg::ST_IDLE) && (state_next == ccs_pkg::ST_IDLE);
         // Saturates so a stuck pulse cannot wrap to a short count
         if (!pat_reg.sub)
            sub_len_reg <= 5'h00;
         else if (sub_len_reg != 5'h1f)
            sub_len_reg <= sub_len_reg + 5'h01;
      end
   end

   ccs_skid_buf u_buf (
      .i_clk_sys (i_clk_sys),
      .i_rstn    (i_rstn),
      .i_valid   (ev_push),
      .o_ready   (buf_ready),
      .i_data    (ev_data),
      .o_valid   (o_line_valid),
      .i_ready   (i_line_ready),
      .o_data    (o_line)
   );

   ccs_pattern_map u_map (
      .i_clk_sys    (i_clk_sys),
      .i_rstn       (i_rstn),
      .i_mode       (i_mode),
      .i_unused_off (i_unused_off),
      .i_pat        (pat_reg),
      .o_pins       (o_pins)
   );

   assign o_busy       = busy_reg;
   assign o_frame_done = done_reg;

   sub_idle_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (state_reg != ccs_pkg::ST_SHUT) |-> !pat_reg.sub) else $error("substrate pulse outside shutter");
   expo_order_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      $fell(pat_reg.sub) |-> state_reg == ccs_pkg::ST_EXPO) else $error("exposure not started at sub fall");
   pd_edge_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (pat_reg.p1t == 2'h1 && $past(pat_reg.p1t) == 2'h2) |-> pat_reg.p4t) else $error("phase four late");
   shut_len_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      $fell(pat_reg.sub) |-> sub_len_reg >= 5'(`CCS_T_SUB_CYC)) else $error("shutter pulse too short");
   line_count_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (state_reg == ccs_pkg::ST_PIXELS && state_next == ccs_pkg::ST_IDLE) |-> line_reg >= lines_min - 12'h1)
      else $error("frame ended early");
   pix_count_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (state_reg == ccs_pkg::ST_PIXELS && state_next != ccs_pkg::ST_PIXELS) |-> pix_reg == pix_min - 12'h1)
      else $error("line ended with wrong pixel count");
   frame_seq_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (state_reg == ccs_pkg::ST_PDXFER && state_next == ccs_pkg::ST_VSHIFT) |=> ##[0:200] state_reg == ccs_pkg::ST_HDELAY)
      else $error("no vertical shift after transfer");
   pix_edge_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      $fell(pat_reg.p6) |-> $past(state_reg) == ccs_pkg::ST_PIXELS) else $error("last phase fell outside readout");
endmodule // ccs_sequencer
`default_nettype wire

// file: rtl/ccs_regs.svh
// Timing counts and mode encodings for the CCD clock sequencer
`ifndef CCS_REGS_SVH
`define CCS_REGS_SVH

`define CCS_CLK_NS            50
// Least times in ns, rounded up to cycles
`define CCS_T_PD_NS           1000
`define CCS_T_PD_CYC          ((`CCS_T_PD_NS + `CCS_CLK_NS - 1) / `CCS_CLK_NS)
`define CCS_T_SUB_NS          1000
`define CCS_T_SUB_CYC         ((`CCS_T_SUB_NS + `CCS_CLK_NS - 1) / `CCS_CLK_NS)
`define CCS_T_HD_NS           1000
`define CCS_T_HD_CYC          ((`CCS_T_HD_NS + `CCS_CLK_NS - 1) / `CCS_CLK_NS)
`define CCS_T_V_NS            1600
`define CCS_T_V_CYC           ((`CCS_T_V_NS + `CCS_CLK_NS - 1) / `CCS_CLK_NS)
`define CCS_T_HS_NS           200
`define CCS_T_HS_CYC          ((`CCS_T_HS_NS + `CCS_CLK_NS - 1) / `CCS_CLK_NS)
// Minimum line and pixel counts
`define CCS_LINES_SHORT       12'd632
`define CCS_LINES_LONG        12'd1264
`define CCS_PIX_SHORT         12'd1213
`define CCS_PIX_LONG          12'd2426
// Readout modes
`define CCS_MODE_QUAD         2'h0
`define CCS_MODE_DUAL_AB      2'h1
`define CCS_MODE_DUAL_AC      2'h2
`define CCS_MODE_SINGLE       2'h3
// Pixel clock divider: pixel phase every n cycles
`define CCS_PIX_DIV           4'h2
`define CCS_CNT_W             12
`define CCS_TMR_W             8

`endif

// file: rtl/ccs_pkg.sv
// Types for the CCD clock sequencer
package ccs_pkg;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_SHUT   = 3'b001,
      ST_EXPO   = 3'b010,
      ST_PDXFER = 3'b011,
      ST_VSHIFT = 3'b100,
      ST_HDELAY = 3'b101,
      ST_PIXELS = 3'b110
   } ccs_state_t;

   // Seven patterns, upper and lower vertical copies
   typedef struct packed {
      logic [1:0] p1t;
      logic [1:0] p1b;
      logic       p2t;
      logic       p2b;
      logic       p3t;
      logic       p3b;
      logic       p4t;
      logic       p4b;
      logic       p5;
      logic       p6;
      logic       p7;
      logic       sub;
   } ccs_pattern_t;

   // Pin drive for every clocked sensor pin; vert phase1 has 3 levels
   typedef struct packed {
      logic [1:0] vert_phase1_upper;
      logic       vert_phase2_upper;
      logic       vert_phase3_upper;
      logic       vert_phase4_upper;
      logic [1:0] vert_phase1_lower;
      logic       vert_phase2_lower;
      logic       vert_phase3_lower;
      logic       vert_phase4_lower;
      logic [3:0] horiz_phase1_storage;
      logic [3:0] horiz_phase2_storage;
      logic [3:0] horiz_last_phase;
      logic [3:0] output_reset_gate;
      logic [3:0] reg_off;
      logic       substrate;
   } ccs_pins_t;

   typedef struct packed {
      logic        line_start;
      logic [11:0] line_idx;
   } ccs_line_t;

endpackage : ccs_pkg

// file: rtl/ccs_skid_buf.sv
// Two-entry buffer for line-start events
`timescale 1ns/1ps
`default_nettype none
module ccs_skid_buf (
   input  wire logic              i_clk_sys,
   input  wire logic              i_rstn,
   input  wire logic              i_valid,
   output logic                   o_ready,
   input  wire ccs_pkg::ccs_line_t i_data,
   output logic                   o_valid,
   input  wire logic              i_ready,
   output ccs_pkg::ccs_line_t     o_data
);
   ccs_pkg::ccs_line_t mem_reg [2];
   ccs_pkg::ccs_line_t head_reg;
   logic [1:0] cnt_reg;
   logic       rd_reg;
   logic       wr_reg;
   logic       valid_reg;
   logic       ready_reg;
   wire        push     = i_valid && (cnt_reg != 2'h2);
   wire        pop      = i_ready && (cnt_reg != 2'h0);
   wire [1:0]  cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
   wire        rd_next  = pop ? ~rd_reg : rd_reg;
   // Entry written this edge may become the head at once
   wire        head_new = push && (wr_reg == rd_next);

   // Flags and head word registered so the outputs come from flops
   assign o_ready = ready_reg;
   assign o_valid = valid_reg;
   assign o_data  = head_reg;

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt_reg <= 2'h0;
         rd_reg  <= 1'b0;
         wr_reg  <= 1'b0;
         mem_reg[0] <= '0;
         mem_reg[1] <= '0;
         head_reg   <= '0;
         valid_reg  <= 1'b0;
         ready_reg  <= 1'b1;
      end else begin
         if (push) begin
            mem_reg[wr_reg] <= i_data;
            wr_reg <= ~wr_reg;
         end
         rd_reg    <= rd_next;
         cnt_reg   <= cnt_next;
         valid_reg <= (cnt_next != 2'h0);
         ready_reg <= (cnt_next != 2'h2);
         head_reg  <= head_new ? i_data : mem_reg[rd_next];
      end
   end

   full_empty_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      cnt_reg <= 2'h2) else $error("buffer count overflow");
endmodule // ccs_skid_buf
`default_nettype wire

// file: rtl/ccs_pattern_map.sv
// Maps seven patterns onto sensor pins by readout mode
`timescale 1ns/1ps
`default_nettype none
`include "ccs_regs.svh"
module ccs_pattern_map (
   input  wire logic                 i_clk_sys,
   input  wire logic                 i_rstn,
   input  wire logic [1:0]           i_mode,
   input  wire logic                 i_unused_off,
   input  wire ccs_pkg::ccs_pattern_t i_pat,
   output ccs_pkg::ccs_pins_t        o_pins
);
   ccs_pkg::ccs_pins_t pins_reg;
   ccs_pkg::ccs_pins_t pins_next;
   wire quad_or_ac = (i_mode == `CCS_MODE_QUAD) || (i_mode == `CCS_MODE_DUAL_AC);
   // Unused c/d held off; b idles too in single and a/c dual
   wire c_off = i_unused_off && ((i_mode == `CCS_MODE_DUAL_AB) || (i_mode == `CCS_MODE_SINGLE));
   wire d_off = i_unused_off && (i_mode != `CCS_MODE_QUAD);
   wire b_off = i_unused_off && ((i_mode == `CCS_MODE_DUAL_AC) || (i_mode == `CCS_MODE_SINGLE));
   wire [3:0] off_vec = {d_off, c_off, b_off, 1'b0};

   always_comb begin
      pins_next = '0;
      pins_next.vert_phase1_upper = quad_or_ac ? i_pat.p1t : i_pat.p1b;
      pins_next.vert_phase2_upper = quad_or_ac ? i_pat.p2t : i_pat.p4b;
      pins_next.vert_phase3_upper = quad_or_ac ? i_pat.p3t : i_pat.p3b;
      pins_next.vert_phase4_upper = quad_or_ac ? i_pat.p4t : i_pat.p2b;
      pins_next.vert_phase1_lower = i_pat.p1b;
      pins_next.vert_phase2_lower = i_pat.p2b;
      pins_next.vert_phase3_lower = i_pat.p3b;
      pins_next.vert_phase4_lower = i_pat.p4b;
      pins_next.substrate         = i_pat.sub;
      pins_next.reg_off           = off_vec;
      for (int r = 0; r < 4; r++) begin
         pins_next.horiz_phase1_storage[r] = off_vec[r] ? 1'b0 : i_pat.p5;
         pins_next.horiz_phase2_storage[r] = off_vec[r] ? 1'b0 : i_pat.p6;
         pins_next.horiz_last_phase[r]     = off_vec[r] ? 1'b0 : i_pat.p6;
         pins_next.output_reset_gate[r]    = off_vec[r] ? 1'b0 : i_pat.p7;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn)
         pins_reg <= '0;
      else
         pins_reg <= pins_next;
   end
   assign o_pins = pins_reg;

   last_phase_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      o_pins.horiz_last_phase == o_pins.horiz_phase2_storage) else $error("last phase differs from storage");
   lower_map_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      ##1 o_pins.vert_phase1_lower == $past(i_pat.p1b)) else $error("lower phase1 mismap");
endmodule // ccs_pattern_map
`default_nettype wire

// file: test/ccs_sensor_model.sv
// Behavioural sensor that watches the clock pins and reports rows, pixels and exposure
`timescale 1ns/1ps
`default_nettype none
module ccs_sensor_model (
   input  wire logic               i_clk_sys,
   input  wire logic               i_rstn,
   input  wire ccs_pkg::ccs_pins_t i_pins,
   output logic [11:0]             o_rows,
   output logic [11:0]             o_pix_last,
   output logic [15:0]             o_expo
);
   logic [1:0]  p1_reg;
   logic        h2l_reg;
   logic        sub_reg;
   logic        expo_run_reg;
   logic        dummy_pend_reg;
   logic [11:0] pix_reg;
   wire         fall_xfer = (p1_reg == 2'h2) && (i_pins.vert_phase1_upper == 2'h1);
   wire         fall_row  = (p1_reg != 2'h0) && (i_pins.vert_phase1_upper == 2'h0);
   wire         fall_pix  = h2l_reg && !i_pins.horiz_last_phase[0];
   wire         fall_sub  = sub_reg && !i_pins.substrate;

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         p1_reg         <= 2'h0;
         h2l_reg        <= 1'b0;
         sub_reg        <= 1'b0;
         expo_run_reg   <= 1'b0;
         dummy_pend_reg <= 1'b0;
         pix_reg        <= 12'h000;
         o_rows         <= 12'h000;
         o_pix_last     <= 12'h000;
         o_expo         <= 16'h0000;
      end else begin
         p1_reg  <= i_pins.vert_phase1_upper;
         h2l_reg <= i_pins.horiz_last_phase[0];
         sub_reg <= i_pins.substrate;
         if (fall_sub) begin
            expo_run_reg <= 1'b1;
            o_expo       <= 16'h0000;
         end else if (fall_xfer) begin
            expo_run_reg <= 1'b0;
         end else if (expo_run_reg) begin
            o_expo <= o_expo + 16'h0001;
         end
         if (fall_xfer) begin
            dummy_pend_reg <= 1'b1;
         end
         if (fall_row) begin
            // First shift after transfer carries dummy plus dark row as one
            if (dummy_pend_reg) begin
               dummy_pend_reg <= 1'b0;
            end else begin
               o_rows <= o_rows + 12'h001;
            end
            // A phase-one drop with no pixels counted since must not wipe the count
            if (pix_reg != 12'h000) begin
               o_pix_last <= pix_reg;
            end
            pix_reg <= 12'h000;
         end else if (fall_pix) begin
            pix_reg <= pix_reg + 12'h001;
         end
      end
   end
endmodule // ccs_sensor_model
`default_nettype wire

// file: test/tb_ccs_sequencer.sv
// Self-checking bench for the CCD clock sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ccs_regs.svh"
module tb_ccs_sequencer;
   logic               i_clk_sys, i_rstn, i_start, i_shutter_en, i_unused_off, i_line_ready;
   logic [1:0]         i_mode;
   logic [15:0]        i_expo_cycles;
   logic [11:0]        i_extra_lines;
   logic               o_line_valid, o_busy, o_frame_done;
   ccs_pkg::ccs_line_t o_line;
   ccs_pkg::ccs_pins_t o_pins;
   logic [11:0]        m_rows, m_pix;
   logic [15:0]        m_expo;
   logic               sub_seen;
   int                 err_total, checks, cyc;

   ccs_sequencer u_dut (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_start(i_start), .i_mode(i_mode),
      .i_shutter_en(i_shutter_en), .i_expo_cycles(i_expo_cycles), .i_extra_lines(i_extra_lines),
      .i_unused_off(i_unused_off), .i_line_ready(i_line_ready), .o_line_valid(o_line_valid),
      .o_line(o_line), .o_pins(o_pins), .o_busy(o_busy), .o_frame_done(o_frame_done));
   ccs_sensor_model u_sensor (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_pins(o_pins),
      .o_rows(m_rows), .o_pix_last(m_pix), .o_expo(m_expo));

   initial begin
      i_clk_sys = 1'b0;
      forever #25 i_clk_sys = ~i_clk_sys;
   end

   task automatic close_out();
      $display("counts: %0d checks, %0d mismatches", checks, err_total);
      if (err_total == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input bit ok, input string msg);
      checks++;
      if (!ok) begin
         err_total++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge i_clk_sys);
   endtask

   // Full frames run millions of cycles, so a hang cut-off well above the planned tests
   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_total++;
         $display("unexpected at %0t: run timed out", $time);
         close_out();
      end
   end

   always @(negedge i_clk_sys) begin
      if (i_rstn === 1'b1) begin
         if (o_pins.substrate === 1'b1) sub_seen = 1'b1;
         chk(o_pins.horiz_last_phase === o_pins.horiz_phase2_storage, "last phase differs");
         chk(((o_pins.horiz_phase2_storage ^ {4{o_pins.horiz_phase2_storage[0]}}) & ~o_pins.reg_off) === 4'h0,
             "clocked register off the a rate");
         // No scenario runs a whole frame, so an end here means too few lines
         chk(o_frame_done === 1'b0, "frame ended before minimum lines");
         for (int r = 0; r < 4; r++) begin
            if (o_pins.reg_off[r] === 1'b1) begin
               chk((o_pins.horiz_phase1_storage[r] | o_pins.horiz_phase2_storage[r]
                    | o_pins.output_reset_gate[r]) === 1'b0, "off register clocked");
            end
         end
      end
   end

   task automatic do_reset();
      i_rstn  = 1'b0;
      i_start = 1'b0;
      tick(5);
      chk(o_busy === 1'b0 && o_pins === '0 && o_line_valid === 1'b0, "outputs not clear in reset");
      i_rstn = 1'b1;
      tick(1);
   endtask

   task automatic go(input logic [1:0] m, input logic sh, input logic off);
      i_mode       = m;
      i_shutter_en = sh;
      i_unused_off = off;
      i_start      = 1'b1;
      tick(1);
      i_start = 1'b0;
      tick(1);
      chk(o_busy === 1'b1, "busy not raised");
   endtask

   task automatic get_line(input logic [11:0] exp_idx);
      int n;
      n            = 0;
      i_line_ready = 1'b1;
      while (o_line_valid !== 1'b1 && n < 30000) begin
         tick(1);
         n++;
      end
      chk(n < 30000 && o_line.line_start === 1'b1 && o_line.line_idx === exp_idx, "line event");
      tick(1);
   endtask

   task automatic t_shutter();
      int n;
      n             = 0;
      i_expo_cycles = 16'h0040;
      go(`CCS_MODE_QUAD, 1'b1, 1'b0);
      while (o_pins.substrate !== 1'b1 && n < 50) begin tick(1); n++; end
      n = 0;
      while (o_pins.substrate === 1'b1 && n < 100) begin tick(1); n++; end
      chk(n == `CCS_T_SUB_CYC, "shutter pulse width");
      n = 0;
      while (o_pins.vert_phase1_upper !== 2'h2 && n < 400) begin tick(1); n++; end
      chk(n < 400, "no photodiode transfer");
      while (o_pins.vert_phase1_upper === 2'h2 && n < 800) begin tick(1); n++; end
      chk(o_pins.vert_phase1_upper === 2'h1 && o_pins.vert_phase4_upper === 1'b1, "phase four late");
      // A start while busy must not restart the frame
      i_start = 1'b1;
      tick(1);
      i_start = 1'b0;
      get_line(12'h000);
      get_line(12'h001);
      chk(m_pix >= `CCS_PIX_SHORT, "too few pixel clocks");
      chk(m_expo >= 16'h0040 && m_expo <= 16'h0040 + `CCS_T_PD_CYC + 16'h0010, "exposure");
      chk(m_rows === 12'h001, "one row past the merged dummy row");
      $display("done: shutter frame");
      do_reset();
   endtask

   task automatic t_stall();
      i_line_ready = 1'b0;
      sub_seen     = 1'b0;
      go(`CCS_MODE_DUAL_AB, 1'b0, 1'b1);
      tick(16000);
      chk(o_line_valid === 1'b1 && o_busy === 1'b1, "stalled frame lost events");
      get_line(12'h000);
      get_line(12'h001);
      get_line(12'h002);
      chk(sub_seen === 1'b0, "substrate pulsed with shutter off");
      $display("done: stalled consumer");
      do_reset();
   endtask

   task automatic t_modes();
      logic [3:0] mask [4];
      mask = '{4'b0000, 4'b1100, 4'b1010, 4'b1110};
      for (int m = 0; m < 4; m++) begin
         go(m[1:0], 1'b0, 1'b1);
         tick(100);
         chk(o_pins.reg_off === mask[m], "unused register mask");
         if (m == 3) begin
            get_line(12'h000);
            get_line(12'h001);
            chk(m_pix >= `CCS_PIX_LONG, "too few pixel clocks single");
         end
         do_reset();
      end
      $display("done: readout modes");
   endtask

   initial begin
      err_total     = 0;
      checks        = 0;
      cyc           = 0;
      sub_seen      = 1'b0;
      i_rstn        = 1'b0;
      i_start       = 1'b0;
      i_mode        = `CCS_MODE_QUAD;
      i_shutter_en  = 1'b0;
      i_expo_cycles = 16'h0000;
      i_extra_lines = 12'h000;
      i_unused_off  = 1'b0;
      i_line_ready  = 1'b1;
      do_reset();
      t_shutter();
      t_stall();
      t_modes();
      close_out();
   end
endmodule // tb_ccs_sequencer
`default_nettype wire
